// ==== hw/media_front_pkg.sv ====
// Shared constants and types for the media thread front end.
// How it works
// R01: Only one of media or 3D pipeline active.
// R02: Pipeline changes only on pipeline switch command.
// R03: Front stage takes work, writes payload, hands thread.
// R04: Front stage only writes the return buffer.
// R05: Spawner stage never touches the return buffer.
// R06: Constant buffer handle forwarded to spawner when enabled.
// R07: Only spawner launches root and child threads.
// R08: Spawner accepts messages only with its identifier.
// R09: Each root thread carries at most one handle.
// R10: Payload handle doubles as root return handle.
// R11: Root reuses its return handle for children.
// R12: At most one persistent root thread alive.
// R13: Unfinished persistent root re-dispatched on restore.
// R14: Synchronized root waits for dispatch-root message.
// R15: Unsynchronized root launches without any message.
package media_front_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W   = 32; // Payload word width
  localparam int unsigned HANDLE_W = 8;  // Return buffer handle width
  localparam int unsigned SFID_W   = 4;  // Shared function id width
  localparam int unsigned CREDIT_W = 4;  // Pending dispatch-root messages

  // ----------------------------------------------------------------
  // Values after reset and fixed codes
  // ----------------------------------------------------------------
  localparam logic [SFID_W-1:0]   SPAWNER_SFID = 4'h7;  // Plain default id
  localparam logic [HANDLE_W-1:0] HANDLE_RST   = 8'h00; // First handle
  localparam logic [HANDLE_W-1:0] HANDLE_STEP  = 8'h01; // Allocator step
  localparam logic [CREDIT_W-1:0] CREDIT_RST   = 4'h0;  // No messages yet
  localparam logic [CREDIT_W-1:0] CREDIT_ONE   = 4'h1;  // One message
  localparam logic [CREDIT_W-1:0] CREDIT_MAX   = 4'hf;  // Counter ceiling
  localparam logic                MEDIA_RST    = 1'b0;  // 3D owns after reset

  // ----------------------------------------------------------------
  // Message kinds and spawner states
  // ----------------------------------------------------------------
  localparam logic MSG_DISPATCH_ROOT = 1'b0; // Release a synchronized root
  localparam logic MSG_SPAWN_CHILD   = 1'b1; // Parent asks for a child

  typedef enum logic [1:0] {
    SP_IDLE      = 2'b00, // Nothing held
    SP_WAIT_SYNC = 2'b01, // Synchronized root held for a message
    SP_LAUNCH    = 2'b10  // Thread presented to the dispatcher
  } spawn_state_type;

endpackage : media_front_pkg

// ==== hw/media_thread_front_end.sv ====
// Front stage and thread spawner stage of the general purpose pipeline.
`timescale 1ns/100ps
`default_nettype none
module media_thread_front_end
  import media_front_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                ce_in,
  // Pipeline switch command
  input  wire logic                pipe_sel_valid_in,
  input  wire logic                pipe_sel_media_in,
  output logic                     media_active_out,
  output logic                     three_d_active_out,
  // Work from the command streamer
  input  wire logic                work_valid_in,
  input  wire logic [DATA_W-1:0]   work_payload_in,
  input  wire logic                work_sync_in,
  input  wire logic                work_prt_in,
  input  wire logic                work_has_ret_in,
  input  wire logic                cb_enable_in,
  input  wire logic [HANDLE_W-1:0] cb_handle_in,
  output logic                     work_ready_out,
  // Return buffer write port, no read side exists
  output logic                     urb_wr_valid_out,
  output logic [HANDLE_W-1:0]      urb_wr_handle_out,
  output logic [DATA_W-1:0]        urb_wr_data_out,
  // Messages from execution units
  input  wire logic                msg_valid_in,
  input  wire logic [SFID_W-1:0]   msg_sfid_in,
  input  wire logic                msg_kind_in,
  input  wire logic [HANDLE_W-1:0] msg_handle_in,
  output logic                     msg_ready_out,
  // Persistent root thread events
  input  wire logic                prt_done_in,
  input  wire logic                ctx_restore_in,
  // Launch toward the thread dispatcher
  input  wire logic                td_ready_in,
  output logic                     td_valid_out,
  output logic                     td_root_out,
  output logic                     td_has_ret_out,
  output logic [HANDLE_W-1:0]      td_handle_out,
  output logic                     td_cb_valid_out,
  output logic [HANDLE_W-1:0]      td_cb_handle_out,
  output logic                     td_prt_out,
  output logic                     td_resume_out
);

  // ----------------------------------------------------------------
  // Pipeline ownership
  // ----------------------------------------------------------------
  logic media_reg, media_next;     // High while media pipeline owns engine
  logic three_d_reg, three_d_next; // Own flop, so no output is a gate

  // Mode moves only on an explicit switch command
  always_comb begin
    media_next = media_reg;
    if (pipe_sel_valid_in) begin
      media_next = pipe_sel_media_in; // R02
    end
    three_d_next = ~media_next; // R01
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      media_reg   <= MEDIA_RST;
      three_d_reg <= ~MEDIA_RST;
    end else if (ce_in) begin
      media_reg   <= media_next;
      three_d_reg <= three_d_next;
    end
  end

  // Each output has its own flop, loaded with opposite values, which keeps them exclusive
  assign media_active_out   = media_reg;  // R01
  assign three_d_active_out = three_d_reg; // R01

  // ----------------------------------------------------------------
  // Front stage: accept, allocate handle, write payload
  // ----------------------------------------------------------------
  logic                root_pend_reg, root_pend_next;     // Thread handed over
  logic                root_sync_reg, root_sync_next;     // Needs a message
  logic                root_prt_reg, root_prt_next;       // Persistent root
  logic                root_ret_reg, root_ret_next;       // Has return handle
  logic [HANDLE_W-1:0] root_handle_reg, root_handle_next; // Return handle
  logic                root_cbv_reg, root_cbv_next;       // Constant buffer on
  logic [HANDLE_W-1:0] root_cb_reg, root_cb_next;         // Constant buffer
  logic [HANDLE_W-1:0] alloc_reg, alloc_next;             // Next free handle
  logic                urb_v_reg, urb_v_next;
  logic [HANDLE_W-1:0] urb_h_reg, urb_h_next;
  logic [DATA_W-1:0]   urb_d_reg, urb_d_next;
  logic                ready_reg, ready_next;
  logic                prt_live_reg, prt_live_next;       // One PERSISTENT_ROOT_THREAD alive
  logic [HANDLE_W-1:0] prt_handle_reg, prt_handle_next;   // Saved for restore
  logic                accept;                             // Work taken now
  logic                launch_root;                        // From spawner below

  // Ready lags the request kind by a cycle, so a second PERSISTENT_ROOT_THREAD is refused here
  assign accept = work_valid_in & ready_reg & ~(prt_live_reg & work_prt_in); // R12

  // Handle is allocated once and used both as payload target and return
  always_comb begin
    root_pend_next   = root_pend_reg;
    root_sync_next   = root_sync_reg;
    root_prt_next    = root_prt_reg;
    root_ret_next    = root_ret_reg;
    root_handle_next = root_handle_reg;
    root_cbv_next    = root_cbv_reg;
    root_cb_next     = root_cb_reg;
    alloc_next       = alloc_reg;
    urb_v_next       = 1'b0;
    urb_h_next       = urb_h_reg;
    urb_d_next       = urb_d_reg;
    prt_live_next    = prt_live_reg;
    prt_handle_next  = prt_handle_reg;
    if (launch_root) begin
      root_pend_next = 1'b0;
    end
    if (prt_done_in) begin
      prt_live_next = 1'b0;
    end
    if (accept) begin
      root_pend_next   = 1'b1;                        // R03
      root_sync_next   = work_sync_in;
      root_prt_next    = work_prt_in;
      root_ret_next    = work_has_ret_in;             // R09
      root_handle_next = alloc_reg;                   // R10
      root_cbv_next    = cb_enable_in;
      root_cb_next     = cb_enable_in ? cb_handle_in : root_cb_reg; // R06
      urb_v_next       = 1'b1;                        // R04
      urb_h_next       = alloc_reg;                   // R10
      urb_d_next       = work_payload_in;             // R03
      alloc_next       = alloc_reg + HANDLE_STEP;
      if (work_prt_in) begin
        prt_live_next   = 1'b1;                       // R12
        prt_handle_next = alloc_reg;
      end
    end
    // Stall further work while a thread is held or a PERSISTENT_ROOT_THREAD would double up
    ready_next = media_next & ~root_pend_next & ~(prt_live_next & work_prt_in); // R12
    ready_next = ready_next & ~accept;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      root_pend_reg   <= 1'b0;
      root_sync_reg   <= 1'b0;
      root_prt_reg    <= 1'b0;
      root_ret_reg    <= 1'b0;
      root_handle_reg <= HANDLE_RST;
      root_cbv_reg    <= 1'b0;
      root_cb_reg     <= HANDLE_RST;
      alloc_reg       <= HANDLE_RST;
      urb_v_reg       <= 1'b0;
      urb_h_reg       <= HANDLE_RST;
      urb_d_reg       <= '0;
      ready_reg       <= 1'b0;
      prt_live_reg    <= 1'b0;
      prt_handle_reg  <= HANDLE_RST;
    end else if (ce_in) begin
      root_pend_reg   <= root_pend_next;
      root_sync_reg   <= root_sync_next;
      root_prt_reg    <= root_prt_next;
      root_ret_reg    <= root_ret_next;
      root_handle_reg <= root_handle_next;
      root_cbv_reg    <= root_cbv_next;
      root_cb_reg     <= root_cb_next;
      alloc_reg       <= alloc_next;
      urb_v_reg       <= urb_v_next;
      urb_h_reg       <= urb_h_next;
      urb_d_reg       <= urb_d_next;
      ready_reg       <= ready_next;
      prt_live_reg    <= prt_live_next;
      prt_handle_reg  <= prt_handle_next;
    end
  end

  assign work_ready_out    = ready_reg;
  assign urb_wr_valid_out  = urb_v_reg;
  assign urb_wr_handle_out = urb_h_reg;
  assign urb_wr_data_out   = urb_d_reg;

  // ----------------------------------------------------------------
  // Spawner stage: messages, launch arbitration, dispatcher port
  // ----------------------------------------------------------------
  spawn_state_type     sp_reg, sp_next;
  logic [CREDIT_W-1:0] credit_reg, credit_next;       // Dispatch-root messages
  logic                child_pend_reg, child_pend_next;
  logic [HANDLE_W-1:0] child_handle_reg, child_handle_next;
  logic                redo_reg, redo_next;            // Restore re-dispatch
  logic                mready_reg, mready_next;
  logic                tdv_reg, tdv_next;
  logic                tdr_reg, tdr_next;
  logic                tdh_reg, tdh_next;
  logic [HANDLE_W-1:0] tdhd_reg, tdhd_next;
  logic                tdcv_reg, tdcv_next;
  logic [HANDLE_W-1:0] tdcb_reg, tdcb_next;
  logic                tdp_reg, tdp_next;
  logic                tdres_reg, tdres_next;
  logic                td_free;                        // Output slot empties
  logic                msg_take;                       // Message accepted
  logic                root_go;                        // Root allowed to leave

  // Only traffic carrying our own identifier is ever taken
  assign msg_take = msg_valid_in & mready_reg & (msg_sfid_in == SPAWNER_SFID); // R08
  assign td_free  = ~tdv_reg | td_ready_in;
  // A synchronized root needs a banked message, others go at once
  assign root_go     = root_pend_reg & (~root_sync_reg | (credit_reg != CREDIT_RST)); // R14 R15
  assign launch_root = td_free & ~redo_reg & root_go;

  // Priority: restore re-dispatch, then root, then child
  always_comb begin
    sp_next           = sp_reg;
    credit_next       = credit_reg;
    child_pend_next   = child_pend_reg;
    child_handle_next = child_handle_reg;
    redo_next         = redo_reg;
    tdv_next          = tdv_reg & ~td_ready_in;
    tdr_next          = tdr_reg;
    tdh_next          = tdh_reg;
    tdhd_next         = tdhd_reg;
    tdcv_next         = tdcv_reg;
    tdcb_next         = tdcb_reg;
    tdp_next          = tdp_reg;
    tdres_next        = tdres_reg;
    if (ctx_restore_in & prt_live_reg & ~prt_done_in) begin
      redo_next = 1'b1; // R13
    end
    if (msg_take & (msg_kind_in == MSG_DISPATCH_ROOT)) begin
      credit_next = credit_next + CREDIT_ONE; // R14
    end
    if (msg_take & (msg_kind_in == MSG_SPAWN_CHILD)) begin
      child_pend_next   = 1'b1;           // R07
      child_handle_next = msg_handle_in;  // R11
    end
    if (td_free & redo_reg) begin
      redo_next  = 1'b0;
      tdv_next   = 1'b1;                  // R13
      tdr_next   = 1'b1;
      tdh_next   = 1'b1;
      tdhd_next  = prt_handle_reg;
      tdcv_next  = 1'b0;
      tdp_next   = 1'b1;
      tdres_next = 1'b1;
    end else if (launch_root) begin
      tdv_next   = 1'b1;                  // R07
      tdr_next   = 1'b1;
      tdh_next   = root_ret_reg;          // R09
      tdhd_next  = root_handle_reg;       // R10
      tdcv_next  = root_cbv_reg;          // R06
      tdcb_next  = root_cb_reg;
      tdp_next   = root_prt_reg;
      tdres_next = 1'b0;
      if (root_sync_reg) begin
        credit_next = credit_next - CREDIT_ONE; // R14
      end
    end else if (td_free & child_pend_reg) begin
      child_pend_next = 1'b0;
      tdv_next   = 1'b1;                  // R07
      tdr_next   = 1'b0;
      tdh_next   = 1'b1;
      tdhd_next  = child_handle_reg;      // R11
      tdcv_next  = 1'b0;
      tdp_next   = 1'b0;
      tdres_next = 1'b0;
    end
    // State tracks what the spawner is doing for observers
    case (sp_reg)
      SP_IDLE, SP_WAIT_SYNC, SP_LAUNCH: begin
        if (tdv_next) begin
          sp_next = SP_LAUNCH;
        end else if (root_pend_next & root_sync_reg) begin
          sp_next = SP_WAIT_SYNC; // R14
        end else begin
          sp_next = SP_IDLE;
        end
      end
      default: begin
        sp_next = SP_IDLE;
      end
    endcase
    // Back-pressure: one child slot, credit counter never wraps
    mready_next = ~child_pend_next & (credit_next != CREDIT_MAX);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sp_reg           <= SP_IDLE;
      credit_reg       <= CREDIT_RST;
      child_pend_reg   <= 1'b0;
      child_handle_reg <= HANDLE_RST;
      redo_reg         <= 1'b0;
      mready_reg       <= 1'b0;
      tdv_reg          <= 1'b0;
      tdr_reg          <= 1'b0;
      tdh_reg          <= 1'b0;
      tdhd_reg         <= HANDLE_RST;
      tdcv_reg         <= 1'b0;
      tdcb_reg         <= HANDLE_RST;
      tdp_reg          <= 1'b0;
      tdres_reg        <= 1'b0;
    end else if (ce_in) begin
      sp_reg           <= sp_next;
      credit_reg       <= credit_next;
      child_pend_reg   <= child_pend_next;
      child_handle_reg <= child_handle_next;
      redo_reg         <= redo_next;
      mready_reg       <= mready_next;
      tdv_reg          <= tdv_next;
      tdr_reg          <= tdr_next;
      tdh_reg          <= tdh_next;
      tdhd_reg         <= tdhd_next;
      tdcv_reg         <= tdcv_next;
      tdcb_reg         <= tdcb_next;
      tdp_reg          <= tdp_next;
      tdres_reg        <= tdres_next;
    end
  end

  // Spawner outputs; it has no return buffer port at all
  assign msg_ready_out    = mready_reg; // R05
  assign td_valid_out     = tdv_reg;
  assign td_root_out      = tdr_reg;
  assign td_has_ret_out   = tdh_reg;
  assign td_handle_out    = tdhd_reg;
  assign td_cb_valid_out  = tdcv_reg;
  assign td_cb_handle_out = tdcb_reg;
  assign td_prt_out       = tdp_reg;
  assign td_resume_out    = tdres_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_take_work;
    ce_in && accept;
  endsequence

  sequence s_root_free;
    ce_in && root_pend_reg && !root_sync_reg && td_free && !redo_reg;
  endsequence

  a_pipe_exclusive: assert property (@(posedge clk_in) disable iff (rst_in) // R01
    media_active_out != three_d_active_out)
    else $error("both or neither pipeline active");

  a_pipe_switch_cmd: assert property (@(posedge clk_in) disable iff (rst_in) // R02
    $changed(media_active_out) |-> $past(pipe_sel_valid_in && ce_in))
    else $error("pipeline changed without switch command");

  a_payload_write: assert property (@(posedge clk_in) disable iff (rst_in) // R03
    s_take_work |=> urb_wr_valid_out && root_pend_reg
                    && urb_wr_data_out == $past(work_payload_in))
    else $error("accepted work not written and handed over");

  a_handle_shared: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    s_take_work ##1 (urb_wr_valid_out && root_ret_reg) |-> urb_wr_handle_out == root_handle_reg)
    else $error("return handle differs from payload handle");

  a_cb_forward: assert property (@(posedge clk_in) disable iff (rst_in) // R06
    s_take_work and cb_enable_in |=> root_cbv_reg && root_cb_reg == $past(cb_handle_in))
    else $error("constant buffer handle not forwarded");

  a_prt_single: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    s_take_work and work_prt_in |-> !prt_live_reg)
    else $error("second persistent root accepted");

  a_prt_restore: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    ce_in && redo_reg && td_free |=> td_valid_out && td_resume_out
                                     && td_handle_out == prt_handle_reg)
    else $error("persistent root not re-dispatched");

  a_sync_hold: assert property (@(posedge clk_in) disable iff (rst_in) // R14
    ce_in && launch_root && root_sync_reg |-> credit_reg != CREDIT_RST)
    else $error("synchronized root launched without message");

  a_unsync_auto: assert property (@(posedge clk_in) disable iff (rst_in) // R15
    s_root_free |=> td_valid_out && td_root_out && !root_pend_reg)
    else $error("unsynchronized root not launched");

  a_sfid_filter: assert property (@(posedge clk_in) disable iff (rst_in) // R08
    ce_in && msg_valid_in && msg_sfid_in != SPAWNER_SFID && !child_pend_reg
    |=> !child_pend_reg)
    else $error("foreign message accepted");

endmodule : media_thread_front_end
`default_nettype wire

// ==== sim/td_model.sv ====
// Behavioural thread dispatcher taking launches after a set stall.
`timescale 1ns/100ps
`default_nettype none
module td_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Launch handshake
  input  wire logic       td_valid_in,
  input  wire logic [3:0] stall_in,
  output logic            td_ready_out,
  output logic [7:0]      launches_out
);
  logic [3:0] wait_reg; // Cycles spent stalling this launch
  // ------------------------------------------------------------
  // Accept logic
  // ------------------------------------------------------------
  // Ready drops after every take, so each launch meets the stall again
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      td_ready_out <= 1'b0;
      wait_reg     <= 4'h0;
      launches_out <= 8'h00;
    end else if (td_valid_in && td_ready_out) begin
      td_ready_out <= 1'b0;
      wait_reg     <= 4'h0;
      launches_out <= launches_out + 8'h01;
    end else if (td_valid_in) begin // Stall, then accept
      td_ready_out <= (wait_reg >= stall_in);
      wait_reg     <= wait_reg + 4'h1;
    end
  end
endmodule : td_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the media thread front end.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import media_front_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                clk_in, rst_in, ce_in, pipe_sel_valid_in, pipe_sel_media_in;
  logic                media_active_out, three_d_active_out, work_valid_in, work_sync_in;
  logic                work_prt_in, work_has_ret_in, cb_enable_in, work_ready_out;
  logic                urb_wr_valid_out, msg_valid_in, msg_kind_in, msg_ready_out;
  logic                prt_done_in, ctx_restore_in, td_ready_in, td_valid_out, td_root_out;
  logic                td_has_ret_out, td_cb_valid_out, td_prt_out, td_resume_out;
  logic [DATA_W-1:0]   work_payload_in, urb_wr_data_out;
  logic [HANDLE_W-1:0] cb_handle_in, urb_wr_handle_out, msg_handle_in, td_handle_out;
  logic [HANDLE_W-1:0] td_cb_handle_out;
  logic [SFID_W-1:0]   msg_sfid_in;
  logic [3:0]          stall;       // Dispatcher stall length
  logic [7:0]          launches;    // Launches seen by the dispatcher
  logic                l_got, l_root, l_ret, l_cbv, l_prt, l_res; // Last launch
  logic [HANDLE_W-1:0] l_h, l_cbh;  // Last launch handles
  int                  fails, n_tests;
  // ------------------------------------------------------------
  // Clock, design and dispatcher
  // ------------------------------------------------------------
  always #20 clk_in = ~clk_in; // 25 MHz
  media_thread_front_end u_dut (.clk_in, .rst_in, .ce_in, .pipe_sel_valid_in,
    .pipe_sel_media_in, .media_active_out, .three_d_active_out, .work_valid_in,
    .work_payload_in, .work_sync_in, .work_prt_in, .work_has_ret_in, .cb_enable_in,
    .cb_handle_in, .work_ready_out, .urb_wr_valid_out, .urb_wr_handle_out,
    .urb_wr_data_out, .msg_valid_in, .msg_sfid_in, .msg_kind_in, .msg_handle_in,
    .msg_ready_out, .prt_done_in, .ctx_restore_in, .td_ready_in, .td_valid_out,
    .td_root_out, .td_has_ret_out, .td_handle_out, .td_cb_valid_out, .td_cb_handle_out,
    .td_prt_out, .td_resume_out);
  td_model u_td (.clk_in(clk_in), .rst_in(rst_in), .td_valid_in(td_valid_out),
    .stall_in(stall), .td_ready_out(td_ready_in), .launches_out(launches));
  // ------------------------------------------------------------
  // Compare tasks and closing
  // ------------------------------------------------------------
  task automatic chk1(input string n, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask : chk1
  task automatic chkh(input string n, input logic [HANDLE_W-1:0] e, input logic [HANDLE_W-1:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chkh
  task automatic chkd(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chkd
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Offers one work item; when taken, checks the buffer write a cycle on
  task automatic send_work(input logic [DATA_W-1:0] p, input logic sy, input logic pr,
                           input logic rt, input logic cb, input logic [HANDLE_W-1:0] eh,
                           input logic exp_take);
    logic tk;
    tk = 1'b0;
    work_payload_in <= p;
    work_sync_in    <= sy;
    work_prt_in     <= pr;
    work_has_ret_in <= rt;
    cb_enable_in    <= cb;
    cb_handle_in    <= 8'h3c;
    work_valid_in   <= 1'b1;
    for (int i = 0; i < 8 && !tk; i++) begin
      @(posedge clk_in);
      tk = (work_ready_out === 1'b1);
    end
    work_valid_in <= 1'b0;
    chk1("work_taken", exp_take, tk);
    if (tk) begin
      @(posedge clk_in);
      chk1("urb_wr_valid", 1'b1, urb_wr_valid_out);
      chkh("urb_wr_handle", eh, urb_wr_handle_out);
      chkd("urb_wr_data", p, urb_wr_data_out);
    end
  endtask : send_work
  // Holds a message until the spawner samples ready
  task automatic send_msg(input logic [SFID_W-1:0] id, input logic k,
                          input logic [HANDLE_W-1:0] h);
    logic tk;
    tk = 1'b0;
    msg_sfid_in   <= id;
    msg_kind_in   <= k;
    msg_handle_in <= h;
    msg_valid_in  <= 1'b1;
    for (int i = 0; i < 8 && !tk; i++) begin
      @(posedge clk_in);
      tk = (msg_ready_out === 1'b1);
    end
    msg_valid_in <= 1'b0;
    chk1("msg_taken", 1'b1, tk);
  endtask : send_msg
  // Waits a bounded time for a launch, checks kind and handle
  task automatic launch(input logic root, input logic [HANDLE_W-1:0] h);
    l_got = 1'b0;
    for (int i = 0; i < 20 && !l_got; i++) begin
      @(posedge clk_in);
      l_got = (td_valid_out === 1'b1 && td_ready_in === 1'b1);
      {l_root, l_ret, l_h, l_cbv, l_cbh, l_prt, l_res} = {td_root_out, td_has_ret_out,
        td_handle_out, td_cb_valid_out, td_cb_handle_out, td_prt_out, td_resume_out};
    end
    chk1("launch_seen", 1'b1, l_got);
    chk1("td_root", root, l_root);
    chkh("td_handle", h, l_h);
  endtask : launch
  // One-cycle strobe: bit 2 select, bit 1 restore, bit 0 done
  task automatic pulse(input logic [2:0] w);
    {pipe_sel_valid_in, ctx_restore_in, prt_done_in} <= w;
    @(posedge clk_in);
    {pipe_sel_valid_in, ctx_restore_in, prt_done_in} <= 3'b000;
  endtask : pulse
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_select;
    chk1("media_active", 1'b0, media_active_out);
    chk1("three_d_active", 1'b1, three_d_active_out);
    chk1("td_valid", 1'b0, td_valid_out);
    send_work(32'h0000_1111, 1'b0, 1'b0, 1'b1, 1'b1, HANDLE_RST, 1'b0);
    pipe_sel_media_in <= 1'b1;
    pulse(3'b100);
    @(posedge clk_in);
    chk1("media_active", 1'b1, media_active_out);
    chk1("three_d_active", 1'b0, three_d_active_out);
  endtask : t_reset_and_select
  task automatic t_unsync_root;
    send_work(32'hcafe_0001, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 1'b1);
    launch(1'b1, 8'h00);
    chk1("td_has_ret", 1'b1, l_ret);
    chk1("td_cb_valid", 1'b1, l_cbv);
    chkh("td_cb_handle", 8'h3c, l_cbh);
  endtask : t_unsync_root
  task automatic t_sync_root_and_child;
    stall <= 4'h3;
    send_work(32'hbeef_0002, 1'b1, 1'b0, 1'b1, 1'b1, 8'h01, 1'b1);
    repeat (6) @(posedge clk_in);
    chk1("td_valid_held", 1'b0, td_valid_out);
    send_msg(4'h3, MSG_DISPATCH_ROOT, 8'h00);
    repeat (4) @(posedge clk_in);
    chk1("td_valid_foreign", 1'b0, td_valid_out);
    send_msg(SPAWNER_SFID, MSG_DISPATCH_ROOT, 8'h00);
    launch(1'b1, 8'h01);
    send_msg(SPAWNER_SFID, MSG_SPAWN_CHILD, 8'h01);
    launch(1'b0, 8'h01);
    stall <= 4'h0;
  endtask : t_sync_root_and_child
  task automatic t_persistent_root;
    send_work(32'h5a5a_0003, 1'b0, 1'b1, 1'b1, 1'b0, 8'h02, 1'b1);
    launch(1'b1, 8'h02);
    chk1("td_prt", 1'b1, l_prt);
    chk1("td_resume", 1'b0, l_res);
    send_work(32'h5a5a_0004, 1'b0, 1'b1, 1'b1, 1'b0, 8'h03, 1'b0);
    pulse(3'b010);
    launch(1'b1, 8'h02);
    chk1("td_prt_restore", 1'b1, l_prt);
    chk1("td_resume", 1'b1, l_res);
    pulse(3'b001);
    send_work(32'h5a5a_0005, 1'b0, 1'b1, 1'b1, 1'b0, 8'h03, 1'b1);
    launch(1'b1, 8'h03);
  endtask : t_persistent_root
  task automatic t_no_return_and_3d;
    send_work(32'h0f0f_0006, 1'b0, 1'b0, 1'b0, 1'b0, 8'h04, 1'b1);
    launch(1'b1, 8'h04);
    chk1("td_has_ret", 1'b0, l_ret);
    chk1("td_cb_valid", 1'b0, l_cbv);
    pipe_sel_media_in <= 1'b0;
    pulse(3'b100);
    @(posedge clk_in);
    chk1("media_active", 1'b0, media_active_out);
    chk1("three_d_active", 1'b1, three_d_active_out);
    send_work(32'h0f0f_0007, 1'b0, 1'b0, 1'b1, 1'b0, 8'h05, 1'b0);
    chkh("launch_count", 8'h07, launches);
  endtask : t_no_return_and_3d
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {clk_in, ce_in, rst_in, pipe_sel_valid_in, pipe_sel_media_in} = 5'b01100;
    {work_valid_in, work_sync_in, work_prt_in, work_has_ret_in, cb_enable_in} = 5'b00000;
    {msg_valid_in, msg_kind_in, prt_done_in, ctx_restore_in} = 4'b0000;
    {work_payload_in, cb_handle_in, msg_handle_in, msg_sfid_in, stall} = '0;
    fails = 0;
    n_tests = 0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset_and_select();
    t_unsync_root();
    t_sync_root_and_child();
    t_persistent_root();
    t_no_return_and_3d();
    wrap_up();
  end
  // Whole run needs about a hundred cycles; a hang ends after 4000
  initial begin
    #(40 * 4000);
    fails++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
